// >>> logic/mie_pkg.sv
`default_nettype none
// ****************************************************************
// shared constants and types of the instruction execute block
// ****************************************************************
package mie_pkg;

    // register byte offsets on the apb slave
    localparam logic [7:0] OFS_INSTR = 8'h00; // issue one instruction
    localparam logic [7:0] OFS_ACC = 8'h04; // working accumulator
    localparam logic [7:0] OFS_STATUS = 8'h08; // status flags
    localparam logic [7:0] OFS_PC = 8'h0C; // program counter
    localparam logic [7:0] OFS_STACK = 8'h10; // push / read top entry
    localparam logic [7:0] OFS_FADDR = 8'h14; // file register pointer
    localparam logic [7:0] OFS_FDATA = 8'h18; // file register at pointer
    localparam logic [7:0] OFS_WDOG = 8'h1C; // watchdog and prescaler
    localparam logic [7:0] OFS_WAKE = 8'h20; // leave low-power state

    // instruction word field positions
    localparam int INS_K_LSB = 0; // 8-bit literal
    localparam int INS_F_LSB = 8; // 7-bit file address
    localparam int INS_D_BIT = 15; // destination select
    localparam int INS_OP_LSB = 16; // 4-bit operation code

    // status word bit positions
    localparam int ST_C = 0; // carry
    localparam int ST_DC = 1; // digit carry
    localparam int ST_Z = 2; // zero
    localparam int ST_PD = 3; // power-down flag
    localparam int ST_TO = 4; // time-out flag
    localparam int ST_GIE = 5; // global interrupt enable
    localparam int ST_SLP = 6; // low-power state, read only
    localparam int WD_PRESC_LSB = 8; // prescaler in watchdog word
    localparam int PC_W = 13; // program counter width

    // reset values
    localparam logic RST_PD = 1'b1;
    localparam logic RST_TO = 1'b1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [12:0] RST_PC = 13'h0000;
    localparam logic [7:0] PRESC_LAST = 8'hFF; // prescaler wrap value
    localparam logic [7:0] WDOG_CLEAR = 8'h00; // watchdog after power-down
    localparam int STACK_DEPTH = 8;

    typedef enum logic [3:0] {
        NOP_OP,
        OR_LITERAL_OP,
        LOAD_LITERAL_OP,
        OR_REGISTER_OP,
        STORE_ACCUMULATOR_OP,
        MOVE_REGISTER_OP,
        INTERRUPT_RETURN_OP,
        ROTATE_LEFT_OP,
        ROTATE_RIGHT_OP,
        LITERAL_RETURN_OP,
        SUBROUTINE_RETURN_OP,
        POWER_DOWN_OP,
        SUBTRACT_FROM_LITERAL_OP,
        XOR_LITERAL_OP
    } mie_op_e;

    // zero test of an 8-bit result
    function automatic logic mie_is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction : mie_is_zero

endpackage : mie_pkg
`default_nettype wire

// >>> logic/mie_file_bank.sv
`default_nettype none
// ****************************************************************
// 128 x 8 file registers, one write port, two read ports
// ****************************************************************
module mie_file_bank
    import mie_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic wrEn, // write strobe
    input wire logic [6:0] wrAddr, // write address
    input wire logic [7:0] wrData, // write data
    input wire logic [6:0] rdAddrA, // operand read address
    output logic [7:0] rdDataA, // operand read data
    input wire logic [6:0] rdAddrB, // software read address
    output logic [7:0] rdDataB // software read data
);

    logic [7:0] mem [128];

    // storage cleared at reset, written by index
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 128; i++)
            begin
                mem[i] <= RST_BYTE;
            end
        end
        else if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
    end

    // asynchronous read ports
    assign rdDataA = mem[rdAddrA];
    assign rdDataB = mem[rdAddrB];

endmodule : mie_file_bank
`default_nettype wire

// >>> logic/mie_alu.sv
`default_nettype none
// ****************************************************************
// result and flag computation for one instruction
// ****************************************************************
module mie_alu
    import mie_pkg::*;
(
    input wire mie_op_e op, // operation
    input wire logic [7:0] accIn, // working accumulator
    input wire logic [7:0] fileIn, // addressed file register
    input wire logic [7:0] lit, // literal
    input wire logic carryIn, // current carry
    input wire logic destFile, // 1: result back to file register
    output logic [7:0] result, // result value
    output logic carryOut, // new carry
    output logic digitOut, // new digit carry
    output logic updCarry, // carry is written
    output logic updDigit, // digit carry is written
    output logic updZero, // zero flag is written
    output logic writeAcc, // result goes to accumulator
    output logic writeFile // result goes to file register
);

    logic [8:0] diff;
    logic [4:0] diffLow;

    // literal minus accumulator in two's complement
    assign diff = {1'b0, lit} + {1'b0, ~accIn} + 9'h001;
    assign diffLow = {1'b0, lit[3:0]} + {1'b0, ~accIn[3:0]} + 5'h01;

    // per-operation result and flag selection
    always_comb
    begin
        result = accIn;
        carryOut = carryIn;
        digitOut = 1'b0;
        updCarry = 1'b0;
        updDigit = 1'b0;
        updZero = 1'b0;
        writeAcc = 1'b0;
        writeFile = 1'b0;
        unique case (op)
            OR_LITERAL_OP:
            begin
                result = accIn | lit;
                updZero = 1'b1;
                writeAcc = 1'b1;
            end
            LOAD_LITERAL_OP, LITERAL_RETURN_OP:
            begin
                result = lit;
                writeAcc = 1'b1;
            end
            OR_REGISTER_OP:
            begin
                result = accIn | fileIn;
                updZero = 1'b1;
                writeAcc = !destFile;
                writeFile = destFile;
            end
            STORE_ACCUMULATOR_OP:
            begin
                result = accIn;
                writeFile = 1'b1;
            end
            MOVE_REGISTER_OP:
            begin
                result = fileIn;
                updZero = 1'b1;
                writeAcc = !destFile;
                writeFile = destFile;
            end
            ROTATE_LEFT_OP:
            begin
                result = {fileIn[6:0], carryIn};
                carryOut = fileIn[7];
                updCarry = 1'b1;
                writeAcc = !destFile;
                writeFile = destFile;
            end
            ROTATE_RIGHT_OP:
            begin
                result = {carryIn, fileIn[7:1]};
                carryOut = fileIn[0];
                updCarry = 1'b1;
                writeAcc = !destFile;
                writeFile = destFile;
            end
            SUBTRACT_FROM_LITERAL_OP:
            begin
                result = diff[7:0];
                carryOut = diff[8];
                digitOut = diffLow[4];
                updCarry = 1'b1;
                updDigit = 1'b1;
                updZero = 1'b1;
                writeAcc = 1'b1;
            end
            XOR_LITERAL_OP:
            begin
                result = accIn ^ lit;
                updZero = 1'b1;
                writeAcc = 1'b1;
            end
            default:
            begin
                result = accIn;
            end
        endcase
    end

endmodule : mie_alu
`default_nettype wire

// >>> logic/mie_core.sv
`default_nettype none
// ****************************************************************
// instruction execute core behind an apb slave
// ****************************************************************
module mie_core
    import mie_pkg::*;
(
    input wire logic mclk, // clock, 50 MHz
    input wire logic rstn, // synchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic oscHalt, // main oscillator stopped
    output logic globalIntEnable // global interrupt enable
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] accReg;
    logic carryReg;
    logic digitReg;
    logic zeroReg;
    logic timeoutReg;
    logic powerDownReg;
    logic gieReg;
    logic sleepReg;
    logic busyReg;
    logic [12:0] pcReg;
    logic [12:0] stackMem [STACK_DEPTH];
    logic [2:0] stackPtr;
    logic [6:0] fileAddrReg;
    logic [7:0] wdogReg;
    logic [7:0] prescReg;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire logic access;
    wire logic wrDone;
    wire logic selInstr;
    wire logic selAcc;
    wire logic selStatus;
    wire logic selPc;
    wire logic selStack;
    wire logic selFaddr;
    wire logic selFdata;
    wire logic selWdog;
    wire logic selWake;
    wire logic mapped;
    wire logic opLegal;
    wire logic insRefused;
    wire logic fire;

    // address decode and transfer qualifiers
    assign access = psel & penable;
    assign wrDone = access & pready & pwrite;
    assign selInstr = (paddr == OFS_INSTR);
    assign selAcc = (paddr == OFS_ACC);
    assign selStatus = (paddr == OFS_STATUS);
    assign selPc = (paddr == OFS_PC);
    assign selStack = (paddr == OFS_STACK);
    assign selFaddr = (paddr == OFS_FADDR);
    assign selFdata = (paddr == OFS_FDATA);
    assign selWdog = (paddr == OFS_WDOG);
    assign selWake = (paddr == OFS_WAKE);
    assign mapped = selInstr | selAcc | selStatus | selPc | selStack
                  | selFaddr | selFdata | selWdog | selWake;

    // an instruction is refused while asleep or with an unknown code
    assign opLegal = (pwdata[INS_OP_LSB +: 4] <= 4'(XOR_LITERAL_OP));
    assign insRefused = selInstr & pwrite & (sleepReg | !opLegal);
    assign fire = wrDone & selInstr & !insRefused;

    // handshake: one stall cycle after a two-cycle instruction
    assign pready = !busyReg;
    assign pslverr = access & (!mapped | insRefused);

    // ****************************************************************
    // operand fetch and execution
    // ****************************************************************
    wire mie_op_e opIn;
    wire logic [7:0] litIn;
    wire logic [6:0] fAddrIn;
    wire logic destIn;
    wire logic [7:0] fileVal;
    wire logic [7:0] fdataVal;
    wire logic [7:0] aluRes;
    wire logic aluCarry;
    wire logic aluDigit;
    wire logic updCarry;
    wire logic updDigit;
    wire logic updZero;
    wire logic aluWrAcc;
    wire logic aluWrFile;
    wire logic opIsReturn;
    wire logic doReturn;
    wire logic doSleep;
    wire logic doPush;
    wire logic [2:0] popPtr;
    wire logic [12:0] topStackEntry;
    wire logic bankWrEn;
    wire logic [6:0] bankWrAddr;
    wire logic [7:0] bankWrData;

    // instruction fields
    assign opIn = mie_op_e'(pwdata[INS_OP_LSB +: 4]);
    assign litIn = pwdata[INS_K_LSB +: 8];
    assign fAddrIn = pwdata[INS_F_LSB +: 7];
    assign destIn = pwdata[INS_D_BIT];

    // returns and power-down
    assign opIsReturn = (opIn == INTERRUPT_RETURN_OP)
                      | (opIn == LITERAL_RETURN_OP)
                      | (opIn == SUBROUTINE_RETURN_OP);
    assign doReturn = fire & opIsReturn;
    assign doSleep = fire & (opIn == POWER_DOWN_OP);
    assign doPush = wrDone & selStack;
    assign popPtr = stackPtr - 3'h1;
    assign topStackEntry = stackMem[popPtr];

    // file write port shared by execution and software
    assign bankWrEn = (fire & aluWrFile) | (wrDone & selFdata);
    assign bankWrAddr = fire ? fAddrIn : fileAddrReg;
    assign bankWrData = fire ? aluRes : pwdata[7:0];

    mie_file_bank u_bank (
        .mclk(mclk),
        .rstn(rstn),
        .wrEn(bankWrEn),
        .wrAddr(bankWrAddr),
        .wrData(bankWrData),
        .rdAddrA(fAddrIn),
        .rdDataA(fileVal),
        .rdAddrB(fileAddrReg),
        .rdDataB(fdataVal)
    );

    mie_alu u_alu (
        .op(opIn),
        .accIn(accReg),
        .fileIn(fileVal),
        .lit(litIn),
        .carryIn(carryReg),
        .destFile(destIn),
        .result(aluRes),
        .carryOut(aluCarry),
        .digitOut(aluDigit),
        .updCarry(updCarry),
        .updDigit(updDigit),
        .updZero(updZero),
        .writeAcc(aluWrAcc),
        .writeFile(aluWrFile)
    );

    // ****************************************************************
    // registers
    // ****************************************************************

    // accumulator
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            accReg <= RST_BYTE;
        else if (fire & aluWrAcc)
            accReg <= aluRes;
        else if (wrDone & selAcc)
            accReg <= pwdata[7:0];
    end

    // arithmetic flags, zero tracks the 8-bit result
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            carryReg <= 1'b0;
            digitReg <= 1'b0;
            zeroReg <= 1'b0;
        end
        else if (fire)
        begin
            if (updCarry)
                carryReg <= aluCarry;
            if (updDigit)
                digitReg <= aluDigit;
            if (updZero)
                zeroReg <= mie_is_zero(aluRes);
        end
        else if (wrDone & selStatus)
        begin
            carryReg <= pwdata[ST_C];
            digitReg <= pwdata[ST_DC];
            zeroReg <= pwdata[ST_Z];
        end
    end

    // interrupt enable, time-out and power-down flags, sleep state
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            gieReg <= 1'b0;
            timeoutReg <= RST_TO;
            powerDownReg <= RST_PD;
            sleepReg <= 1'b0;
        end
        else
        begin
            if (fire & (opIn == INTERRUPT_RETURN_OP))
                gieReg <= 1'b1;
            else if (wrDone & selStatus)
                gieReg <= pwdata[ST_GIE];
            if (doSleep)
            begin
                timeoutReg <= 1'b1;
                powerDownReg <= 1'b0;
                sleepReg <= 1'b1;
            end
            else if (wrDone & selWake & pwdata[0])
                sleepReg <= 1'b0;
        end
    end

    // program counter and return stack
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pcReg <= RST_PC;
            stackPtr <= 3'h0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stackMem[i] <= RST_PC;
        end
        else if (doReturn)
        begin
            pcReg <= topStackEntry;
            stackPtr <= popPtr;
        end
        else if (doPush)
        begin
            stackMem[stackPtr] <= pwdata[PC_W-1:0];
            stackPtr <= stackPtr + 3'h1;
        end
        else if (wrDone & selPc)
            pcReg <= pwdata[PC_W-1:0];
    end

    // stall flag, file pointer
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            busyReg <= 1'b0;
            fileAddrReg <= 7'h00;
        end
        else
        begin
            busyReg <= doReturn;
            if (wrDone & selFaddr)
                fileAddrReg <= pwdata[6:0];
        end
    end

    // watchdog counts mclk through the prescaler, keeps running while asleep
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            prescReg <= RST_BYTE;
            wdogReg <= RST_BYTE;
        end
        else if (doSleep)
        begin
            prescReg <= RST_BYTE;
            wdogReg <= WDOG_CLEAR;
        end
        else
        begin
            prescReg <= prescReg + 8'h01;
            if (prescReg == PRESC_LAST)
                wdogReg <= wdogReg + 8'h01;
        end
    end

    // ****************************************************************
    // read data and outputs
    // ****************************************************************
    wire logic [31:0] statusWord;

    // read mux of register contents
    assign statusWord = {25'h000_0000, sleepReg, gieReg, timeoutReg,
                         powerDownReg, zeroReg, digitReg, carryReg};
    assign prdata = selAcc ? {24'h00_0000, accReg}
                  : selStatus ? statusWord
                  : selPc ? {19'h0_0000, pcReg}
                  : selStack ? {19'h0_0000, topStackEntry}
                  : selFaddr ? {25'h000_0000, fileAddrReg}
                  : selFdata ? {24'h00_0000, fdataVal}
                  : selWdog ? {16'h0000, prescReg, wdogReg}
                  : selWake ? {31'h0000_0000, sleepReg}
                  : 32'h0000_0000;
    assign oscHalt = sleepReg;
    assign globalIntEnable = gieReg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence seqReturnIssued;
        doReturn;
    endsequence
    sequence seqOneStall;
        !pready ##1 pready;
    endsequence

    chk_or_literal: assert property (fire && opIn == OR_LITERAL_OP |=>
        accReg == ($past(accReg) | $past(litIn))
        && zeroReg == mie_is_zero(accReg) && $stable(carryReg))
        else $error("or literal result or flags wrong");
    chk_load_literal: assert property (fire && opIn == LOAD_LITERAL_OP
        |=> accReg == $past(litIn) && $stable(zeroReg) && $stable(carryReg))
        else $error("load literal wrong");
    chk_or_register: assert property (fire && opIn == OR_REGISTER_OP
        && !destIn |=> accReg == ($past(accReg) | $past(fileVal)))
        else $error("or register result wrong");
    chk_dest_file: assert property (fire && destIn && opIn inside
        {OR_REGISTER_OP, MOVE_REGISTER_OP, ROTATE_LEFT_OP, ROTATE_RIGHT_OP}
        |-> bankWrEn && bankWrAddr == fAddrIn ##1 $stable(accReg))
        else $error("destination file write wrong");
    chk_store_acc: assert property (fire && opIn == STORE_ACCUMULATOR_OP
        |-> bankWrEn && bankWrData == accReg ##1 $stable(zeroReg))
        else $error("store accumulator wrong");
    chk_move_zero: assert property (fire && opIn == MOVE_REGISTER_OP
        |=> zeroReg == mie_is_zero($past(fileVal)))
        else $error("move register zero test wrong");
    chk_int_return: assert property (fire && opIn == INTERRUPT_RETURN_OP
        |=> gieReg && pcReg == $past(topStackEntry))
        else $error("interrupt return wrong");
    chk_rotate_left: assert property (fire && opIn == ROTATE_LEFT_OP
        && !destIn |=> accReg == {$past(fileVal[6:0]), $past(carryReg)}
        && carryReg == $past(fileVal[7]))
        else $error("rotate left wrong");
    chk_rotate_right: assert property (fire && opIn == ROTATE_RIGHT_OP
        && !destIn |=> accReg == {$past(carryReg), $past(fileVal[7:1])}
        && carryReg == $past(fileVal[0]))
        else $error("rotate right wrong");
    chk_return_stall: assert property (seqReturnIssued |=> seqOneStall)
        else $error("return not two cycles");
    chk_power_down: assert property (doSleep |=> wdogReg == WDOG_CLEAR
        && prescReg == RST_BYTE && timeoutReg && !powerDownReg)
        else $error("power-down flags wrong");
    chk_osc_halt: assert property (doSleep |=> oscHalt [*2])
        else $error("oscillator not halted");
    chk_sub_literal: assert property (fire
        && opIn == SUBTRACT_FROM_LITERAL_OP
        |=> accReg == 8'($past(litIn) - $past(accReg))
        && carryReg == ($past(litIn) >= $past(accReg)))
        else $error("subtract from literal wrong");
    chk_xor_literal: assert property (fire && opIn == XOR_LITERAL_OP
        |=> accReg == ($past(accReg) ^ $past(litIn))
        && zeroReg == (accReg == 8'h00))
        else $error("xor literal wrong");

endmodule : mie_core
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
// ****************************************************************
// self-checking bench of the instruction execute core
// ****************************************************************
module testbench
    import mie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r32;
    logic pready, pslverr, oscHalt, globalIntEnable;
    logic [3:0] ops [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8,
        4'hC, 4'hD};
    logic [3:0] rops [3] = '{4'h6, 4'h9, 4'hA};
    int error_cnt = 0, checks_done = 0, seed = 93;
    // 50 MHz clock
    always #10 mclk = ~mclk;
    mie_core dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .oscHalt(oscHalt),
        .globalIntEnable(globalIntEnable));
    // counts, verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    // one comparison
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk
    // one apb transfer, read data and error land in rd and err
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            close_out();
        end
    endtask : apb
    // expected {acc, file, z dc c} after one instruction
    function automatic logic [18:0] model(input logic [3:0] op,
        input logic d, input logic [7:0] k, f, w, input logic [2:0] s);
        logic [7:0] r;
        logic [2:0] n;
        logic wa;
        n = s;
        case (op)
            4'h1: r = w | k;
            4'h2: r = k;
            4'h3: r = w | f;
            4'h4: r = w;
            4'h5: r = f;
            4'h7: r = {f[6:0], s[0]};
            4'h8: r = {s[0], f[7:1]};
            4'hC: r = k - w;
            default: r = w ^ k;
        endcase
        wa = (op inside {4'h3, 4'h5, 4'h7, 4'h8}) ? !d : (op != 4'h4);
        if (op inside {4'h1, 4'h3, 4'h5, 4'hC, 4'hD})
            n[2] = (r == 8'h00);
        if (op == 4'h7)
            n[0] = f[7];
        if (op == 4'h8)
            n[0] = f[0];
        if (op == 4'hC)
            n[1:0] = {k[3:0] >= w[3:0], k >= w};
        return {wa ? r : w, wa ? f : r, n};
    endfunction : model
    // main sequence
    initial
    begin : main
        logic [18:0] e;
        logic [3:0] op;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        apb(0, 8'h08, 32'h0000_0000);
        chk("status", 32'h0000_0018, rd);
        $display("test reset done");
        for (int i = 0; i < 60; i++)
        begin
            r32 = $random(seed);
            op = ops[r32[27:24] % 4'd9];
            if (i < 2)
                op = i ? 4'hD : 4'hC;
            e = {r32[31:24], r32[23:16], r32[2:0]};
            r32 = $random(seed);
            if (i < 2)
                r32[7:0] = r32[23:16];
            apb(1, 8'h04, {24'h0, r32[23:16]});
            apb(1, 8'h08, {29'h0, e[2:0]});
            apb(1, 8'h14, {25'h0, r32[30:24]});
            apb(1, 8'h18, {24'h0, e[10:3]});
            apb(1, 8'h00, {12'h0, op, r32[31:24], r32[7:0]});
            e = model(op, r32[31], r32[7:0], e[10:3], r32[23:16], e[2:0]);
            apb(0, 8'h04, 32'h0000_0000);
            chk("acc", {24'h0, e[18:11]}, rd);
            apb(0, 8'h18, 32'h0000_0000);
            chk("file", {24'h0, e[10:3]}, rd);
            apb(0, 8'h08, 32'h0000_0000);
            chk("flags", {29'h0, e[2:0]}, {29'h0, rd[2:0]});
        end
        $display("test random done");
        foreach (rops[j])
        begin
            r32 = $random(seed);
            apb(1, 8'h10, {19'h0, r32[12:0]});
            apb(0, 8'h10, 32'h0000_0000);
            chk("top entry", {19'h0, r32[12:0]}, rd);
            apb(1, 8'h08, 32'h0000_0005);
            apb(1, 8'h00, {12'h0, rops[j], 8'h00, r32[23:16]});
            apb(0, 8'h0C, 32'h0000_0000);
            chk("pc", {19'h0, r32[12:0]}, rd);
            apb(0, 8'h08, 32'h0000_0000);
            chk("status", {26'h0, rops[j] == 4'h6, 5'h1D}, rd);
            chk("gie", {31'h0, rops[j] == 4'h6}, {31'h0, globalIntEnable});
            if (rops[j] == 4'h9)
                apb(0, 8'h04, 32'h0000_0000);
            if (rops[j] == 4'h9)
                chk("acc", {24'h0, r32[23:16]}, rd);
        end
        $display("test returns done");
        apb(1, 8'h00, 32'h000B_0000);
        apb(0, 8'h1C, 32'h0000_0000);
        chk("watchdog", 32'h0000_0000, {24'h0, rd[7:0]});
        chk("prescaler", 32'h0000_0001, {31'h0, rd[15:8] < 8'h10});
        apb(0, 8'h08, 32'h0000_0000);
        chk("pd to", 32'h0000_0050, {25'h0, rd[6:3], 3'h0});
        chk("halt", 32'h0000_0001, {31'h0, oscHalt});
        apb(1, 8'h00, 32'h0002_0033);
        chk("asleep", 32'h0000_0001, {31'h0, err});
        apb(1, 8'h20, 32'h0000_0001);
        apb(0, 8'h40, 32'h0000_0000);
        chk("awake", 32'h0000_0000, {31'h0, oscHalt});
        chk("unmapped", 32'h0000_0001, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, rd);
        // unknown op code is refused, no-operation is taken and changes nothing
        apb(1, 8'h04, 32'h0000_00A5);
        apb(1, 8'h00, 32'h000E_0055);
        chk("bad op", 32'h0000_0001, {31'h0, err});
        apb(1, 8'h00, 32'h0000_0055);
        chk("nop", 32'h0000_0000, {31'h0, err});
        apb(0, 8'h04, 32'h0000_0000);
        chk("acc kept", 32'h0000_00A5, rd);
        $display("test power-down done");
        close_out();
    end : main
endmodule : testbench
`default_nettype wire
